// ---- bench/tcp_checker.sv ----
// concurrent checks on the bus and output pin of the timer control block
`timescale 1ns/10ps
`include "tcp_defs.vh"
module tcp_checker
(
	input wire                   CLK,
	input wire                   RESET,
	input wire                   PSEL,
	input wire                   PENABLE,
	input wire                   PWRITE,
	input wire [`TCP_ADDR_W-1:0] PADDR,
	input wire [31:0]            PWDATA,
	input wire [3:0]             PSTRB,
	input wire [31:0]            PRDATA,
	input wire                   PREADY,
	input wire                   PSLVERR,
	input wire [2:0]             TIMER_MODE,
	input wire                   FIRST_IS_CAPTURE,
	input wire                   SECOND_IS_CAPTURE,
	input wire                   TIMER_OUTPUT_PIN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_done(w, idx);
		PSEL && PENABLE && PREADY && PWRITE == w && PADDR[17:2] == idx;
	endsequence
	sequence s_wr(idx);
		s_done(1'b1, idx) ##0 PSTRB[0];
	endsequence
	AST_ONE_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("no ready after one wait");
	AST_READY_PULSE: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	AST_ERR_UNMAPPED: assert property (PSLVERR |-> PREADY &&
		(PADDR[17:2] < `TCP_IDX_PRESCALE || PADDR[17:2] > `TCP_IDX_OUTCTL))
		else $error("error on mapped place");
	AST_UPPER_ZERO: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_OUTCTL_READ: assert property (s_done(1'b0, `TCP_IDX_OUTCTL) |-> PRDATA[7:6] == 2'h0 && PRDATA[3:2] == 2'h0)
		else $error("self clearing bits read set");
	AST_MODE_BITS: assert property (s_wr(`TCP_IDX_CAPCMP) |=>
		##1 {SECOND_IS_CAPTURE, FIRST_IS_CAPTURE} == $past({PWDATA[2], PWDATA[0]}, 2))
		else $error("mode outputs differ");
	AST_OUT_OFF: assert property (s_wr(`TCP_IDX_OUTCTL) ##0 !PWDATA[0] |=> ##1 !TIMER_OUTPUT_PIN)
		else $error("pin driven while off");
	AST_LEVEL_CMD: assert property (s_wr(`TCP_IDX_OUTCTL) ##0 PWDATA[0] && PWDATA[3] != PWDATA[2]
		&& TIMER_MODE[2:1] == 2'h0 |=> ##1 TIMER_OUTPUT_PIN == $past(PWDATA[3], 2))
		else $error("level command lost");
endmodule // tcp_checker
bind tcp_ctrl tcp_checker u_checker (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TIMER_MODE(TIMER_MODE), .FIRST_IS_CAPTURE(FIRST_IS_CAPTURE), .SECOND_IS_CAPTURE(SECOND_IS_CAPTURE),
	.TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN));

// ---- bench/tcp_pins.sv ----
// model of the two external trigger and event input pins
`timescale 1ns/10ps
module tcp_pins
(
	input  wire       CLK,
	input  wire [1:0] LEVEL,
	input  wire [1:0] GLITCH,
	output reg        FIRST_INPUT_PIN,
	output reg        SECOND_INPUT_PIN
);
	initial {SECOND_INPUT_PIN, FIRST_INPUT_PIN} = 2'h0;
	// a glitch inverts a pin for one clock only, too short for the filter
	always @(posedge CLK)
		{SECOND_INPUT_PIN, FIRST_INPUT_PIN} <= LEVEL ^ GLITCH;
endmodule // tcp_pins

// ---- bench/timer_capture_output_prescale_ctrl_bench.sv ----
// self-checking bench for the timer capture, output and prescale control
`timescale 1ns/10ps
`include "tcp_defs.vh"
module timer_capture_output_prescale_ctrl_bench;
	logic        clk, reset, psel, penable, pwrite, m1, m2, ovf, pready, pslverr;
	logic        tick, cap1, cap2, fic, sic, cclr, tout, pin1, pin2;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [2:0]  mode;
	logic [1:0]  lvl, gl;
	logic [9:0]  q[$];
	logic [9:0]  n;
	logic [7:0]  r;
	int          errors, total_checks, i;
	int          c[4] = '{0, 0, 0, 0};
	int          b[4];
	int          dv[3] = '{1, 4, 256};
	int          ea[3] = '{1, 0, 1};
	int          eb[3] = '{1, 2, 1};
	logic [7:0]  tp[3] = '{8'h10, 8'h30, 8'h00};
	tcp_ctrl DUT (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIMER_MODE(mode),
		.MATCH_FIRST(m1), .MATCH_SECOND(m2), .OVERFLOW(ovf), .FIRST_INPUT_PIN(pin1), .SECOND_INPUT_PIN(pin2),
		.COUNT_TICK(tick), .CAPTURE_FIRST(cap1), .CAPTURE_SECOND(cap2), .FIRST_IS_CAPTURE(fic),
		.SECOND_IS_CAPTURE(sic), .COUNTER_CLEAR(cclr), .TIMER_OUTPUT_PIN(tout));
	tcp_pins PINS (.CLK(clk), .LEVEL(lvl), .GLITCH(gl), .FIRST_INPUT_PIN(pin1), .SECOND_INPUT_PIN(pin2));
	task automatic cmp(string s, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task cyc(int t);
		repeat (t) @(posedge clk);
	endtask
	// e holds {read, error, data}
	task apb(logic [15:0] a, logic w, logic [7:0] d, logic [9:0] e);
		int k;
		q.push_back(e);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 2'h0, 24'h0, d};
		cyc(1);
		penable <= 1'b1;
		cyc(1);
		for (k = 0; pready !== 1'b1; k++)
		begin
			if (k == 20)
			begin
				errors++;
				complete_run;
			end
			cyc(1);
		end
		{psel, penable} <= 2'h0;
		cyc(1);
	endtask
	task hit(logic [2:0] p, logic e);
		{ovf, m2, m1} <= p;
		cyc(1);
		{ovf, m2, m1} <= 3'h0;
		cyc(3);
		cmp("out", {7'h0, e}, {7'h0, tout});
	endtask
	task cnt(int k, int e);
		cmp("strobes", 8'(e), 8'(c[k] - b[k]));
	endtask
	task go(logic [7:0] p, logic [7:0] k);
		mode <= 3'h0;
		apb(`TCP_IDX_PRESCALE, 1'b1, p, 10'h0);
		apb(`TCP_IDX_CAPCMP, 1'b1, k, 10'h0);
		b = c;
		mode <= 3'h2;
	endtask
	always @(posedge clk)
	begin
		c <= '{c[0] + cap1, c[1] + cap2, c[2] + tick, c[3] + cclr};
		if (pready === 1'b1)
		begin
			n = q.pop_front();
			cmp("slverr", {7'h0, n[8]}, {7'h0, pslverr});
			if (n[9])
				cmp("rdata", n[7:0], prdata[7:0]);
		end
	end
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, m1, m2, ovf, lvl, gl, mode} = 0;
		reset = 1'b1;
		pstrb = 4'hF;
		void'($urandom(95));
		cyc(10);
		reset <= 1'b0;
		apb(`TCP_IDX_PRESCALE, 1'b0, 8'h0, 10'h200);
		apb(`TCP_IDX_OUTCTL, 1'b0, 8'h0, 10'h200);
		apb(16'hFF64, 1'b1, 8'hFF, 10'h100);
		apb(16'hFF64, 1'b0, 8'h0, 10'h300);
		repeat (3)
		begin
			r = $urandom;
			// the prohibited edge code 10 is turned into 11
			r[6] = r[6] | r[7];
			r[4] = r[4] | r[5];
			apb(`TCP_IDX_PRESCALE, 1'b1, r, 10'h0);
			apb(`TCP_IDX_PRESCALE, 1'b0, 8'h0, {2'h2, r & 8'hF3});
			apb(`TCP_IDX_CAPCMP, 1'b1, r, 10'h0);
			apb(`TCP_IDX_CAPCMP, 1'b0, 8'h0, {2'h2, r & 8'h07});
		end
		pstrb <= 4'hE;
		apb(`TCP_IDX_CAPCMP, 1'b1, ~r, 10'h0);
		pstrb <= 4'hF;
		apb(`TCP_IDX_CAPCMP, 1'b0, 8'h0, {2'h2, r & 8'h07});
		apb(`TCP_IDX_CAPCMP, 1'b1, 8'h0, 10'h0);
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'hB3, 10'h0);
		apb(`TCP_IDX_OUTCTL, 1'b0, 8'h0, 10'h233);
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'h0B, 10'h0);
		mode <= 3'h2;
		hit(3'h1, 1'b0);
		hit(3'h2, 1'b0);
		mode <= 3'h0;
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'h13, 10'h0);
		mode <= 3'h2;
		hit(3'h2, 1'b1);
		hit(3'h1, 1'b0);
		mode <= 3'h0;
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'h23, 10'h0);
		mode <= 3'h2;
		hit(3'h1, 1'b0);
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'h63, 10'h0);
		apb(`TCP_IDX_OUTCTL, 1'b0, 8'h0, 10'h223);
		hit(3'h1, 1'b1);
		hit(3'h4, 1'b1);
		hit(3'h1, 1'b1);
		mode <= 3'h6;
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'h63, 10'h0);
		b = c;
		hit(3'h1, 1'b1);
		cnt(3, 1);
		mode <= 3'h0;
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'h05, 10'h0);
		hit(3'h0, 1'b0);
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'h08, 10'h0);
		hit(3'h0, 1'b0);
		apb(`TCP_IDX_OUTCTL, 1'b1, 8'h01, 10'h0);
		hit(3'h0, 1'b1);
		lvl <= 2'h2;
		go(8'h40, 8'h01);
		cyc(12);
		gl <= 2'h2;
		cyc(1);
		gl <= 2'h0;
		cyc(12);
		lvl <= 2'h0;
		cyc(12);
		cnt(0, 1);
		for (i = 0; i < 3; i++)
		begin
			go(tp[i], 8'h07);
			lvl <= 2'h1;
			cyc(12);
			lvl <= 2'h0;
			cyc(12);
			cnt(0, ea[i]);
			cnt(1, eb[i]);
			go(8'(i), 8'h0);
			// two extra cycles cover the registered tick and its count
			cyc(dv[i] * 8 + 2);
			cnt(2, 8);
		end
		go(8'h13, 8'h0);
		repeat (3)
		begin
			lvl <= 2'h1;
			cyc(6);
			lvl <= 2'h0;
			cyc(6);
		end
		cnt(2, 3);
		mode <= 3'h0;
		apb(`TCP_IDX_PRESCALE, 1'b1, 8'h10, 10'h0);
		b = c;
		mode <= 3'h4;
		lvl <= 2'h1;
		cyc(8);
		lvl <= 2'h0;
		cyc(8);
		cnt(3, 1);
		complete_run;
	end
endmodule // timer_capture_output_prescale_ctrl_bench

// ---- core/tcp_ctrl.v ----
// capture/compare control, timer output flip-flop and count clock prescaler with pin edge detection
`timescale 1ns/10ps
`include "tcp_defs.vh"
// Notes on behaviour
// - second register mode bit: 0 compare, 1 capture
// - first capture: second pin, or first pin reversed
// - first register mode bit: 0 compare, 1 capture
// - reversed trigger with both edges never captures
// - one-shot trigger starts pulse, reads zero
// - one-shot enable: 0 successive, 1 one-shot
// - one-shot only without clear-on-match mode
// - second match toggles output when enabled
// - first match toggles output when enabled
// - level bits: keep, clear, set; read zero
// - output pin low unless output enabled
// - second pin edge: fall, rise, both
// - first pin edge: fall, rise, both
// - count clock full, /4, /256, pin edge
// - enable compares pin with held level
// - edge needs two equal consecutive samples
// - clear-on-match mode clears counter on first match, only while first register is compare
module tcp_ctrl
(
	input  wire                   CLK,
	input  wire                   RESET,
	input  wire                   PSEL,
	input  wire                   PENABLE,
	input  wire                   PWRITE,
	input  wire [`TCP_ADDR_W-1:0] PADDR,
	input  wire [31:0]            PWDATA,
	input  wire [3:0]             PSTRB,
	output reg  [31:0]            PRDATA,
	output reg                    PREADY,
	output reg                    PSLVERR,
	input  wire [2:0]             TIMER_MODE,
	input  wire                   MATCH_FIRST,
	input  wire                   MATCH_SECOND,
	input  wire                   OVERFLOW,
	input  wire                   FIRST_INPUT_PIN,
	input  wire                   SECOND_INPUT_PIN,
	output reg                    COUNT_TICK,
	output reg                    CAPTURE_FIRST,
	output reg                    CAPTURE_SECOND,
	output reg                    FIRST_IS_CAPTURE,
	output reg                    SECOND_IS_CAPTURE,
	output reg                    COUNTER_CLEAR,
	output reg                    TIMER_OUTPUT_PIN
);

	// reset images held as parameters so their fields can be selected
	localparam [7:0] rst_prm = `TCP_RST_PRESCALE;
	localparam [7:0] rst_crc = `TCP_RST_CAPCMP;
	localparam [7:0] rst_toc = `TCP_RST_OUTCTL;

	reg  [1:0]  in2_edge;
	reg  [1:0]  in1_edge;
	reg  [1:0]  clk_sel;
	reg         second_reg_mode_sel;
	reg         first_reg_trigger_sel;
	reg         first_reg_mode_sel;
	reg         oneshot_enable;
	reg         invert_on_second_match;
	reg         invert_on_first_match;
	reg         out_pin_enable;
	reg         out_ff;
	reg         oneshot_armed;
	reg  [7:0]  divider;
	reg  [1:0]  sync1;
	reg  [1:0]  sync2;
	reg  [1:0]  samp_a;
	reg  [1:0]  samp_b;
	reg  [1:0]  lvl;
	reg         presc_tick;
	reg  [7:0]  rd_byte;

	wire [1:0]  mode_hi;
	wire        run;
	wire        match_clr_mode;
	wire        pin_clr_mode;
	wire        samp_tick;
	wire [1:0]  agree;
	wire [1:0]  changed;
	wire [1:0]  rise;
	wire [1:0]  fall;
	wire [1:0]  edge_v;
	wire [1:0]  es_hi;
	wire [1:0]  es_lo;
	wire        rev_first;
	wire        bus_access;
	wire        bus_done;
	wire        wr;
	wire        hit_prm;
	wire        hit_crc;
	wire        hit_toc;
	wire        os_trig;
	wire        toggle_ok;
	wire        toggle;
	wire [1:0]  lvl_cmd;

	assign mode_hi        = TIMER_MODE[2:1];
	assign run            = (mode_hi != `TCP_MODE_STOP);
	assign match_clr_mode = (mode_hi == `TCP_MODE_MATCH_CLR);
	assign pin_clr_mode   = (mode_hi == `TCP_MODE_PIN_CLR);

	// prescaler output; with pin clock the pin samples at the full rate
	always @*
	begin
		case (clk_sel)
			`TCP_CLK_FULL:   presc_tick = 1'b1;
			`TCP_CLK_DIV4:   presc_tick = ((divider & `TCP_DIV4_MASK) == `TCP_DIV4_MASK);
			`TCP_CLK_DIV256: presc_tick = (divider == `TCP_DIV256_LAST);
			`TCP_CLK_PIN:    presc_tick = 1'b1;
			default:         presc_tick = 1'b1;
		endcase
	end

	always @(posedge CLK)
	begin
		if (RESET)
			divider <= 8'h00;
		else if (run)
			divider <= divider + 8'h01;
		else
			divider <= 8'h00;
	end

	// stopped: keep sampling so the first enabled tick sees the present pin level
	assign samp_tick = presc_tick | ~run;
	assign agree     = ~(samp_a ^ samp_b);
	assign changed   = agree & (samp_b ^ lvl) & {2{presc_tick & run}};
	assign rise      = changed & samp_b;
	assign fall      = changed & ~samp_b;
	assign es_hi     = {in2_edge[1], in1_edge[1]};
	assign es_lo     = {in2_edge[0], in1_edge[0]};
	// 10 selects nothing
	assign edge_v    = (rise & es_lo) | (fall & ~(es_hi ^ es_lo));
	// opposite phase; a both-edge selection leaves nothing to capture
	assign rev_first = (rise[0] & (in1_edge == `TCP_EDGE_FALL)) |
	                   (fall[0] & (in1_edge == `TCP_EDGE_RISE));

	always @(posedge CLK)
	begin
		if (RESET)
		begin
			sync1  <= 2'h0;
			sync2  <= 2'h0;
			samp_a <= 2'h0;
			samp_b <= 2'h0;
			lvl    <= 2'h0;
		end
		else
		begin
			sync1 <= {SECOND_INPUT_PIN, FIRST_INPUT_PIN};
			sync2 <= sync1;
			if (samp_tick)
			begin
				samp_a <= sync2;
				samp_b <= samp_a;
			end
			// held level frozen while stopped
			if (presc_tick && run)
				lvl <= (lvl & ~agree) | (samp_b & agree);
		end
	end

	assign bus_access = PSEL & PENABLE;
	assign bus_done   = bus_access & PREADY;
	assign wr         = bus_done & PWRITE & PSTRB[0];
	assign hit_prm    = (PADDR[`TCP_ADDR_W-1:2] == `TCP_IDX_PRESCALE);
	assign hit_crc    = (PADDR[`TCP_ADDR_W-1:2] == `TCP_IDX_CAPCMP);
	assign hit_toc    = (PADDR[`TCP_ADDR_W-1:2] == `TCP_IDX_OUTCTL);
	assign os_trig    = wr & hit_toc & PWDATA[`TCP_TOC_OS_TRIG] & oneshot_enable;
	assign lvl_cmd    = (wr & hit_toc) ? {PWDATA[`TCP_TOC_LVL_SET], PWDATA[`TCP_TOC_LVL_CLR]} : 2'h0;

	always @*
	begin
		rd_byte = 8'h00;
		if (hit_prm)
			rd_byte = {in2_edge, in1_edge, 2'h0, clk_sel};
		else if (hit_crc)
			rd_byte = {5'h00, second_reg_mode_sel, first_reg_trigger_sel, first_reg_mode_sel};
		else if (hit_toc)
			rd_byte = {2'h0, oneshot_enable, invert_on_second_match, 2'h0,
			           invert_on_first_match, out_pin_enable};
	end

	// one wait state keeps every bus output registered
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end
		else
		begin
			PREADY  <= bus_access & ~PREADY;
			// unmapped word: error answer, nothing stored
			PSLVERR <= bus_access & ~PREADY & ~(hit_prm | hit_crc | hit_toc);
			if (bus_access && !PREADY && !PWRITE)
				PRDATA <= {24'h000000, rd_byte};
			else if (!bus_access)
				PRDATA <= 32'h00000000;
		end
	end

	// writes are taken whenever they come; keeping the counter stopped is up to software
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			{in2_edge, in1_edge, clk_sel} <= {rst_prm[7:4], rst_prm[1:0]};
			{second_reg_mode_sel, first_reg_trigger_sel, first_reg_mode_sel} <= rst_crc[2:0];
			{oneshot_enable, invert_on_second_match} <= rst_toc[5:4];
			{invert_on_first_match, out_pin_enable}  <= rst_toc[1:0];
		end
		else if (wr)
		begin
			if (hit_prm)
			begin
				in2_edge <= PWDATA[`TCP_PRM_IN2_HI:`TCP_PRM_IN2_LO];
				in1_edge <= PWDATA[`TCP_PRM_IN1_HI:`TCP_PRM_IN1_LO];
				clk_sel  <= PWDATA[`TCP_PRM_CLK_HI:`TCP_PRM_CLK_LO];
			end
			if (hit_crc)
			begin
				second_reg_mode_sel   <= PWDATA[`TCP_CRC_SECOND_MODE];
				first_reg_trigger_sel <= PWDATA[`TCP_CRC_FIRST_TRIG];
				first_reg_mode_sel    <= PWDATA[`TCP_CRC_FIRST_MODE];
			end
			if (hit_toc)
			begin
				oneshot_enable         <= PWDATA[`TCP_TOC_OS_EN];
				invert_on_second_match <= PWDATA[`TCP_TOC_INV_SECOND];
				invert_on_first_match  <= PWDATA[`TCP_TOC_INV_FIRST];
				out_pin_enable         <= PWDATA[`TCP_TOC_OUT_EN];
			end
		end
	end

	// one-shot: matches only act between a trigger and the next overflow
	always @(posedge CLK)
	begin
		if (RESET)
			oneshot_armed <= 1'b0;
		else if ((os_trig || (pin_clr_mode && edge_v[0] && oneshot_enable)) && !match_clr_mode)
			oneshot_armed <= 1'b1;
		else if (OVERFLOW || !oneshot_enable)
			oneshot_armed <= 1'b0;
	end

	// enabled matches on both registers in one cycle cancel out
	assign toggle_ok = ~oneshot_enable | oneshot_armed;
	assign toggle    = toggle_ok & run & ((MATCH_FIRST & invert_on_first_match) ^
	                   (MATCH_SECOND & invert_on_second_match));

	always @(posedge CLK)
	begin
		if (RESET)
			out_ff <= 1'b0;
		else if (lvl_cmd == 2'h1)
			out_ff <= 1'b0;
		else if (lvl_cmd == 2'h2)
			out_ff <= 1'b1;
		else if (toggle)
			out_ff <= ~out_ff;
	end

	always @(posedge CLK)
	begin
		if (RESET)
		begin
			COUNT_TICK        <= 1'b0;
			CAPTURE_FIRST     <= 1'b0;
			CAPTURE_SECOND    <= 1'b0;
			FIRST_IS_CAPTURE  <= 1'b0;
			SECOND_IS_CAPTURE <= 1'b0;
			COUNTER_CLEAR     <= 1'b0;
			TIMER_OUTPUT_PIN  <= 1'b0;
		end
		else
		begin
			COUNT_TICK        <= (clk_sel == `TCP_CLK_PIN) ? edge_v[0] : (presc_tick & run);
			CAPTURE_FIRST     <= first_reg_mode_sel &
			                     (first_reg_trigger_sel ? rev_first : edge_v[1]);
			CAPTURE_SECOND    <= second_reg_mode_sel & edge_v[0];
			FIRST_IS_CAPTURE  <= first_reg_mode_sel;
			SECOND_IS_CAPTURE <= second_reg_mode_sel;
			COUNTER_CLEAR     <= (match_clr_mode & MATCH_FIRST & ~first_reg_mode_sel) |
			                     (pin_clr_mode & edge_v[0]);
			TIMER_OUTPUT_PIN  <= out_pin_enable & out_ff;
		end
	end

endmodule // tcp_ctrl

// ---- core/tcp_defs.vh ----
// register map, field positions and codes of the timer capture/output/prescale control
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH
`define TCP_ADDR_W          18
`define TCP_IDX_W           16
`define TCP_IDX_PRESCALE    16'hFF61
`define TCP_IDX_CAPCMP      16'hFF62
`define TCP_IDX_OUTCTL      16'hFF63
`define TCP_RST_PRESCALE    8'h00
`define TCP_RST_CAPCMP      8'h00
`define TCP_RST_OUTCTL      8'h00
`define TCP_PRM_IN2_HI      7
`define TCP_PRM_IN2_LO      6
`define TCP_PRM_IN1_HI      5
`define TCP_PRM_IN1_LO      4
`define TCP_PRM_CLK_HI      1
`define TCP_PRM_CLK_LO      0
`define TCP_CRC_SECOND_MODE 2
`define TCP_CRC_FIRST_TRIG  1
`define TCP_CRC_FIRST_MODE  0
`define TCP_TOC_OS_TRIG     6
`define TCP_TOC_OS_EN       5
`define TCP_TOC_INV_SECOND  4
`define TCP_TOC_LVL_SET     3
`define TCP_TOC_LVL_CLR     2
`define TCP_TOC_INV_FIRST   1
`define TCP_TOC_OUT_EN      0
`define TCP_CLK_FULL        2'h0
`define TCP_CLK_DIV4        2'h1
`define TCP_CLK_DIV256      2'h2
`define TCP_CLK_PIN         2'h3
`define TCP_DIV4_MASK       8'h03
`define TCP_DIV256_LAST     8'hFF
`define TCP_MODE_STOP       2'h0
`define TCP_MODE_PIN_CLR    2'h2
`define TCP_MODE_MATCH_CLR  2'h3
`define TCP_EDGE_FALL       2'h0
`define TCP_EDGE_RISE       2'h1
`endif
